// File: rtl/dphst_pkg.sv
// constants, opcodes and state types for the single-wire debug pin block
// assumes one 250 MHz clock; one serial clock cycle equals one clk cycle
package dphst_pkg;
   // ==========================================
   // widths
   localparam int CNT_W = 10;
   localparam int PIN_N = 3;
   localparam int PIN_DBG = 0;
   localparam int PIN_EXTERNAL_BUS_CLOCK = 1;
   localparam int PIN_TLO = 2;
   // ==========================================
   // serial timing, in serial clock cycles
   localparam logic [CNT_W-1:0] BIT_SAMPLE = 10'h00a;
   localparam logic [CNT_W-1:0] TX_HOLD = 10'h00d;
   localparam logic [CNT_W-1:0] SYNC_MIN = 10'h080;
   localparam logic [CNT_W-1:0] SYNC_DLY = 10'h010;
   localparam logic [CNT_W-1:0] SYNC_LOW = 10'h080;
   localparam logic [CNT_W-1:0] ACK_LOW = 10'h010;
   localparam logic [CNT_W-1:0] ACK_MIN_GAP = 10'h020;
   localparam logic [CNT_W-1:0] CMD_END_TICK = 10'h010;
   localparam logic [CNT_W-1:0] TIMEOUT = 10'h200;
   // gap counted from the last bit's sample point, not its end tick
   localparam logic [CNT_W-1:0] ACK_GAP_CNT = ACK_MIN_GAP + CMD_END_TICK - BIT_SAMPLE;
   // ==========================================
   // frame lengths in bits
   localparam logic [5:0] LEN_CTRL = 6'h08;
   localparam logic [5:0] LEN_READ = 6'h18;
   localparam logic [5:0] LEN_WRITE = 6'h28;
   localparam logic [5:0] DATA_BITS = 6'h10;
   localparam logic [5:0] OP_LAST = 6'h07;
   // ==========================================
   // reset values
   localparam logic ACK_EN_RST = 1'h0;
   // ==========================================
   // opcode table
   localparam logic [7:0] OP_ACK_EN = 8'h01;
   localparam logic [7:0] OP_ACK_DIS = 8'h02;
   localparam logic [7:0] OP_HALT_TO_DEBUG_INSTRUCTION = 8'h03;
   localparam logic [7:0] OP_GO = 8'h04;
   localparam logic [7:0] OP_GO_UNTIL = 8'h05;
   localparam logic [7:0] OP_STEP = 8'h06;
   localparam logic [7:0] OP_RUN_WITH_TAGS_CMD = 8'h07;
   localparam logic [7:0] OP_READ = 8'h08;
   localparam logic [7:0] OP_WRITE = 8'h09;
   // ==========================================
   // types
   typedef enum logic [2:0] {
      CL_NONE = 3'b000,
      CL_READ = 3'b001,
      CL_WRITE = 3'b010,
      CL_CTRL = 3'b011,
      CL_HS = 3'b100
   } dphst_cls_t;
   typedef enum logic [2:0] {
      ST_RX = 3'b000,
      ST_EXEC = 3'b001,
      ST_ACKWAIT = 3'b010,
      ST_PULSE = 3'b011,
      ST_TX = 3'b100,
      ST_SYNC_HI = 3'b101,
      ST_SYNC_DLY = 3'b110
   } dphst_state_t;
endpackage

// File: rtl/dphst_pin_if.sv
// carrier for raw pin levels and their filtered levels and falling edges
// assumes all members are in the clk domain except raw
`timescale 1ns/1ns
interface dphst_pin_if;
   logic [2:0] raw;
   logic [2:0] lvl;
   logic [2:0] fall;
   modport sync (input raw, output lvl, output fall);
   modport user (output raw, input lvl, input fall);
endinterface

// File: rtl/dphst_sync.sv
// three-flop pin filter; a level change counts once stages two and three agree
// assumes pins idle high (pulled up)
`timescale 1ns/1ns
module dphst_sync
   import dphst_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // pins
   dphst_pin_if.sync pins
);
   // ==========================================
   // per-pin filter
   for (genvar g = 0; g < PIN_N; g++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      always_ff @(posedge clk) begin
         if (!rstn) begin
            s1_q <= 1'h1;
            s2_q <= 1'h1;
            s3_q <= 1'h1;
            lvl_q <= 1'h1;
         end else begin
            s1_q <= pins.raw[g];
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
               lvl_q <= s3_q;
            end
         end
      end
      // s1 is read only by s2, so edges never see a metastable sample
      assign pins.lvl[g] = lvl_q;
      assign pins.fall[g] = lvl_q && !s2_q && !s3_q;
   end
endmodule

// File: rtl/dphst_core.sv
// single-wire debug port: command decode, handshake, sync reply, stepping, tags
// assumes cpu and memory handshakes are on clk; pins are asynchronous
`timescale 1ns/1ns
module dphst_core
   import dphst_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // debug serial pin, open drain with speedup
   input wire logic debug_serial_pin_i,
   output logic debug_serial_pin_o,
   output logic debug_serial_pin_oe,
   // tag pins
   input wire logic external_bus_clock,
   input wire logic low_byte_tag_in,
   input wire logic low_byte_strobe_en,
   // memory access
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_done,
   // processor control
   input wire logic halt_to_debug_instruction_active,
   output logic enter_halt_to_debug_instruction_req,
   output logic go_req,
   output logic single_step_cmd,
   output logic run_with_tags_cmd,
   output logic tag_valid,
   output logic tag_hi,
   output logic tag_lo,
   // status
   output logic handshake_on
);
   // ==========================================
   // pin filters
   dphst_pin_if pin_if ();
   assign pin_if.raw = {low_byte_tag_in, external_bus_clock, debug_serial_pin_i};
   dphst_sync u_sync (
      .clk(clk),
      .rstn(rstn),
      .pins(pin_if.sync)
   );
   wire pin_lvl = pin_if.lvl[PIN_DBG];
   wire pin_fall = pin_if.fall[PIN_DBG];
   wire external_bus_clock_fall = pin_if.fall[PIN_EXTERNAL_BUS_CLOCK];
   wire tlo_lvl = pin_if.lvl[PIN_TLO];
   // ==========================================
   // state
   dphst_state_t st_q, st_d;
   dphst_cls_t cls_q, cls_d;
   logic [7:0] op_q, op_d;
   logic [39:0] sh_q, sh_d;
   logic [5:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] since_q, since_d, gap_q, gap_d, pcnt_q, pcnt_d;
   logic [15:0] tx_q, tx_d;
   logic arm_q, arm_d, phase_q, phase_d, psync_q, psync_d, hlow_q;
   logic tx_drv_q, tx_drv_d, ack_en_q, ack_en_d, tagging_q, tagging_d;
   logic mem_req_q, mem_req_d, mem_we_q, mem_we_d;
   logic [15:0] addr_q, addr_d, wdata_q, wdata_d;
   logic enter_q, enter_d, go_q, go_d, step_q, step_d, halt_to_debug_instruction_q;
   logic tag_valid_q, tag_hi_q, tag_lo_q;
   // ==========================================
   // decode
   wire halt_to_debug_instruction_rise = halt_to_debug_instruction_active && !halt_to_debug_instruction_q;
   wire drv_busy = (st_q == ST_PULSE) || tx_drv_q;
   // own drive and tag traffic must not look like host edges
   wire fall_ok = pin_fall && !drv_busy && !tagging_q;
   wire sample = (st_q == ST_RX) && arm_q && (since_q == BIT_SAMPLE);
   wire [39:0] sh_nx = {sh_q[38:0], pin_lvl};
   wire [7:0] cur_op = (cnt_q == OP_LAST) ? sh_nx[7:0] : op_q;
   wire is_hs = (cur_op == OP_ACK_EN) || (cur_op == OP_ACK_DIS);
   wire is_ctl = (cur_op >= OP_HALT_TO_DEBUG_INSTRUCTION) && (cur_op <= OP_RUN_WITH_TAGS_CMD);
   wire dphst_cls_t cur_cls = (cur_op == OP_READ) ? CL_READ :
                              (cur_op == OP_WRITE) ? CL_WRITE :
                              is_ctl ? CL_CTRL : is_hs ? CL_HS : CL_NONE;
   wire [5:0] cur_len = (cur_cls == CL_READ) ? LEN_READ :
                        (cur_cls == CL_WRITE) ? LEN_WRITE : LEN_CTRL;
   wire rx_bad = sample && (cnt_q == OP_LAST) && (cur_cls == CL_NONE);
   wire rx_done = sample && !rx_bad && (cnt_q + 6'h01 == cur_len);
   wire in_sync = (st_q == ST_SYNC_HI) || (st_q == ST_SYNC_DLY) || (st_q == ST_PULSE);
   wire sync_det = !tagging_q && !in_sync && hlow_q && !pin_lvl && (since_q == SYNC_MIN);
   // with handshake on a read waits in exec or ackwait, out of reach of the timeout
   wire to_hit = !tagging_q && (since_q == TIMEOUT - 10'h001) &&
                 (((st_q == ST_RX) && (cnt_q != 6'h00)) || (st_q == ST_TX));
   wire is_mem = (cls_q == CL_READ) || (cls_q == CL_WRITE);
   wire exec_done = is_mem ? (mem_req_q && mem_done) :
                    (op_q == OP_HALT_TO_DEBUG_INSTRUCTION) ? halt_to_debug_instruction_active :
                    (op_q == OP_GO) ? !halt_to_debug_instruction_active :
                    (cls_q == CL_HS) ? 1'h1 :
                    (phase_q && halt_to_debug_instruction_active);
   wire need_ack = (op_q == OP_ACK_EN) || (ack_en_q && (op_q != OP_ACK_DIS));
   wire [CNT_W-1:0] plen = psync_q ? SYNC_LOW : ACK_LOW;
   wire after_ack = (cls_q == CL_READ) && !psync_q;
   // ==========================================
   // next state
   always_comb begin
      st_d = st_q;
      cls_d = cls_q;
      op_d = op_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      pcnt_d = pcnt_q;
      tx_d = tx_q;
      phase_d = phase_q;
      psync_d = psync_q;
      tx_drv_d = tx_drv_q;
      ack_en_d = ack_en_q;
      tagging_d = tagging_q;
      mem_req_d = mem_req_q;
      mem_we_d = mem_we_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      enter_d = 1'h0;
      go_d = 1'h0;
      step_d = 1'h0;
      since_d = fall_ok ? '0 : (since_q == TIMEOUT) ? since_q : since_q + 10'h001;
      gap_d = (gap_q == ACK_GAP_CNT) ? gap_q : gap_q + 10'h001;
      arm_d = fall_ok ? 1'h1 : sample ? 1'h0 : arm_q;
      if (halt_to_debug_instruction_rise) begin
         tagging_d = 1'h0;
      end
      case (st_q)
         ST_RX: begin
            if (sample) begin
               sh_d = sh_nx;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == OP_LAST) begin
                  op_d = cur_op;
                  cls_d = cur_cls;
               end
            end
            if (rx_bad) begin
               cnt_d = '0;
            end else if (rx_done) begin
               cnt_d = '0;
               gap_d = '0;
               phase_d = 1'h0;
               mem_req_d = (cur_cls == CL_READ) || (cur_cls == CL_WRITE);
               mem_we_d = (cur_cls == CL_WRITE);
               addr_d = (cur_cls == CL_WRITE) ? sh_nx[31:16] : sh_nx[15:0];
               wdata_d = sh_nx[15:0];
               enter_d = (cur_op == OP_HALT_TO_DEBUG_INSTRUCTION);
               go_d = (cur_op == OP_GO) || (cur_op == OP_GO_UNTIL) || (cur_op == OP_RUN_WITH_TAGS_CMD);
               step_d = (cur_op == OP_STEP);
               if (cur_op == OP_RUN_WITH_TAGS_CMD) begin
                  tagging_d = 1'h1;
               end else begin
                  st_d = ST_EXEC;
               end
            end
         end
         ST_EXEC: begin
            if (!halt_to_debug_instruction_active) begin
               phase_d = 1'h1;
            end
            if (exec_done) begin
               mem_req_d = 1'h0;
               if (cls_q == CL_READ) begin
                  tx_d = mem_rdata;
               end
               if (op_q == OP_ACK_EN) begin
                  ack_en_d = 1'h1;
               end else if (op_q == OP_ACK_DIS) begin
                  ack_en_d = 1'h0;
               end
               st_d = need_ack ? ST_ACKWAIT : (cls_q == CL_READ) ? ST_TX : ST_RX;
            end
         end
         ST_ACKWAIT: begin
            if ((gap_q == ACK_GAP_CNT) && pin_lvl) begin
               st_d = ST_PULSE;
               pcnt_d = '0;
               psync_d = 1'h0;
            end
         end
         ST_PULSE: begin
            pcnt_d = pcnt_q + 10'h001;
            if (pcnt_q == plen) begin
               st_d = after_ack ? ST_TX : ST_RX;
               psync_d = 1'h0;
            end
         end
         ST_TX: begin
            if (fall_ok) begin
               tx_drv_d = !tx_q[15];
               tx_d = {tx_q[14:0], 1'h0};
               cnt_d = cnt_q + 6'h01;
            end else if (since_q == TX_HOLD) begin
               tx_drv_d = 1'h0;
               if (cnt_q == DATA_BITS) begin
                  st_d = ST_RX;
                  cnt_d = '0;
               end
            end
         end
         ST_SYNC_HI: begin
            if (pin_lvl) begin
               st_d = ST_SYNC_DLY;
               pcnt_d = '0;
            end
         end
         ST_SYNC_DLY: begin
            pcnt_d = pcnt_q + 10'h001;
            if (pcnt_q == SYNC_DLY - 10'h001) begin
               st_d = ST_PULSE;
               pcnt_d = '0;
               psync_d = 1'h1;
            end
         end
         default: st_d = ST_RX;
      endcase
      // soft reset drops any partial frame and any pending acknowledge
      if (sync_det || to_hit) begin
         st_d = sync_det ? ST_SYNC_HI : ST_RX;
         cnt_d = '0;
         arm_d = 1'h0;
         mem_req_d = 1'h0;
         tx_drv_d = 1'h0;
      end
   end
   // ==========================================
   // registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q <= ST_RX;
         cls_q <= CL_NONE;
         op_q <= '0;
         sh_q <= '0;
         cnt_q <= '0;
         since_q <= '0;
         gap_q <= '0;
         pcnt_q <= '0;
         tx_q <= '0;
         {arm_q, phase_q, psync_q, tx_drv_q, tagging_q, hlow_q} <= '0;
         ack_en_q <= ACK_EN_RST;
         {mem_req_q, mem_we_q, enter_q, go_q, step_q, halt_to_debug_instruction_q} <= '0;
         addr_q <= '0;
         wdata_q <= '0;
      end else begin
         st_q <= st_d;
         cls_q <= cls_d;
         op_q <= op_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         since_q <= since_d;
         gap_q <= gap_d;
         pcnt_q <= pcnt_d;
         tx_q <= tx_d;
         {arm_q, phase_q, psync_q, tx_drv_q, tagging_q, hlow_q} <=
            {arm_d, phase_d, psync_d, tx_drv_d, tagging_d, fall_ok || (hlow_q && !pin_lvl)};
         ack_en_q <= ack_en_d;
         {mem_req_q, mem_we_q, enter_q, go_q, step_q} <=
            {mem_req_d, mem_we_d, enter_d, go_d, step_d};
         halt_to_debug_instruction_q <= halt_to_debug_instruction_active;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
      end
   end
   // ==========================================
   // tag sampling; the cpu queue carries each tag with its fetch
   always_ff @(posedge clk) begin
      if (!rstn) begin
         {tag_valid_q, tag_hi_q, tag_lo_q} <= '0;
      end else begin
         tag_valid_q <= tagging_q && external_bus_clock_fall;
         if (tagging_q && external_bus_clock_fall) begin
            tag_hi_q <= !pin_lvl;
            tag_lo_q <= !tlo_lvl && low_byte_strobe_en;
         end
      end
   end
   // ==========================================
   // outputs
   assign debug_serial_pin_oe = drv_busy;
   assign debug_serial_pin_o = (st_q == ST_PULSE) && (pcnt_q == plen);
   assign mem_req = mem_req_q;
   assign mem_we = mem_we_q;
   assign mem_addr = addr_q;
   assign mem_wdata = wdata_q;
   assign enter_halt_to_debug_instruction_req = enter_q;
   assign go_req = go_q;
   assign single_step_cmd = step_q;
   assign run_with_tags_cmd = tagging_q;
   assign tag_valid = tag_valid_q;
   assign tag_hi = tag_hi_q;
   assign tag_lo = tag_lo_q;
   assign handshake_on = ack_en_q;
   // ==========================================
   // checks
   logic [CNT_W-1:0] low_run_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         low_run_q <= '0;
      end else if (debug_serial_pin_oe && !debug_serial_pin_o) begin
         low_run_q <= low_run_q + 10'h001;
      end else begin
         low_run_q <= '0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence ack_start;
      $rose(st_q == ST_PULSE) && !psync_q;
   endsequence
   sequence ack_shape;
      (low_run_q == ACK_LOW) ##1 !debug_serial_pin_oe;
   endsequence
   AST_RST_OFF: assert property ($rose(rstn) |-> !ack_en_q)
      else $error("handshake on after reset");
   AST_HS_SET: assert property ((st_q == ST_EXEC) && (op_q == OP_ACK_EN) |=> ack_en_q)
      else $error("enable command did not set handshake");
   AST_HS_ACK: assert property ((st_q == ST_EXEC) && (op_q == OP_ACK_EN)
      |=> (st_q == ST_ACKWAIT) || (st_q == ST_SYNC_HI) || (st_q == ST_RX))
      else $error("enable command not queued for acknowledge");
   AST_ACK_SHAPE: assert property (debug_serial_pin_o && !psync_q |-> ack_shape)
      else $error("acknowledge pulse shape wrong");
   AST_ACK_GAP: assert property (ack_start |-> $past(gap_q) == ACK_GAP_CNT)
      else $error("acknowledge too early");
   AST_SYNC_LOW: assert property (debug_serial_pin_o && psync_q
      |-> low_run_q == SYNC_LOW)
      else $error("sync reply low time wrong");
   AST_SOFT_RST: assert property (sync_det
      |=> (st_q == ST_SYNC_HI) && !mem_req_q && cnt_q == 0)
      else $error("sync did not soft reset");
   AST_TIMEOUT: assert property (to_hit |=> (st_q == ST_RX) && (cnt_q == 0))
      else $error("timeout did not discard frame");
   AST_NO_TAG_ACK: assert property ((st_q == ST_RX) && rx_done && (cur_op == OP_RUN_WITH_TAGS_CMD)
      |=> (st_q == ST_RX) [*8])
      else $error("acknowledge after tagged run");
   AST_TAG_OFF: assert property ($rose(halt_to_debug_instruction_active) |=> !tagging_q)
      else $error("tagging survived background entry");
   AST_LO_TAG: assert property (tag_valid_q && tag_lo_q |-> $past(low_byte_strobe_en))
      else $error("low tag without low strobe");
   AST_READ_ACK: assert property ((st_q == ST_EXEC) && (cls_q == CL_READ) && !mem_done
      |=> st_q != ST_ACKWAIT)
      else $error("read acknowledged before bus cycle");
   AST_UNTIL_ACK: assert property ((st_q == ST_EXEC) && (op_q == OP_GO_UNTIL)
      && !phase_q && !sync_det |=> st_q == ST_EXEC)
      else $error("run-until acknowledged before leaving background");
endmodule

// File: dv/dphst_probe.sv
// debug probe stand-in on the single-wire debug pin
// assumes a pulled-up wire; the probe only pulls low
`timescale 1ns/1ns
module dphst_probe (
   // clock
   input wire logic clk,
   // wire level and probe pull-down
   input wire logic pin,
   output logic p_lo
);
   // =======================
   // bit frames, 12 clk for a one and 21 clk for a zero
   int cyc = 0;
   int fall_t = 0;
   int rel_t = 0;
   initial p_lo = 1'h0;
   always @(posedge clk) cyc <= cyc + 1;
   task automatic bit_out(input logic b);
      @(negedge clk);
      p_lo = 1'h1;
      fall_t = cyc;
      repeat (b ? 6 : 15) @(negedge clk);
      p_lo = 1'h0;
      repeat (5) @(negedge clk);
   endtask
   task automatic byte_out(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) bit_out(v[i]);
   endtask
   task automatic word_out(input logic [15:0] v);
      byte_out(v[15:8]);
      byte_out(v[7:0]);
   endtask
   // short low starts each bit; sample well inside the target's drive
   task automatic read_in(output logic [15:0] v);
      for (int i = 15; i >= 0; i--) begin
         @(negedge clk);
         p_lo = 1'h1;
         repeat (5) @(negedge clk);
         p_lo = 1'h0;
         repeat (7) @(negedge clk);
         v[i] = pin;
         repeat (8) @(negedge clk);
      end
   endtask
   // long low, then release; pull-up gives the rise
   task automatic sync_req();
      @(negedge clk);
      p_lo = 1'h1;
      repeat (140) @(negedge clk);
      p_lo = 1'h0;
      rel_t = cyc;
   endtask
endmodule

// File: dv/debug_pin_handshake_sync_tag_tb.sv
// self-checking bench: probe, memory and cpu stand-ins around the core
// assumes serial clock equals clk
`timescale 1ns/1ns
module debug_pin_handshake_sync_tag_tb;
   import dphst_pkg::*;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic ebc = 1'h1;
   logic tlo = 1'h1;
   logic lse = 1'h0;
   logic done = 1'h0;
   logic bg = 1'h0;
   logic oe_q = 1'h0;
   logic [15:0] rdata = 16'h0000;
   logic o, oe, req, we, ebr, go, step, tagm, tv, thi, tlo_q, hs, p_lo, cap_we;
   logic [15:0] addr, wdata, cap_a, cap_d, v, a, d;
   logic [2:0] k, r;
   int seed = 5291;
   int failures = 0;
   int cmp_count = 0;
   int pulses = 0, p0 = 0, low_n = 0, last_low = 0, ack_t = 0, done_t = 0, bg_t = 0;
   int steps = 0;
   wire pin = oe ? o : !p_lo;
   always #2 clk = ~clk;
   dphst_core u_dphst_core (
      .clk(clk), .rstn(rstn), .debug_serial_pin_i(pin), .debug_serial_pin_o(o),
      .debug_serial_pin_oe(oe), .external_bus_clock(ebc), .low_byte_tag_in(tlo),
      .low_byte_strobe_en(lse), .mem_req(req), .mem_we(we), .mem_addr(addr),
      .mem_wdata(wdata), .mem_rdata(rdata), .mem_done(done), .halt_to_debug_instruction_active(bg),
      .enter_halt_to_debug_instruction_req(ebr), .go_req(go), .single_step_cmd(step),
      .run_with_tags_cmd(tagm), .tag_valid(tv), .tag_hi(thi), .tag_lo(tlo_q),
      .handshake_on(hs));
   dphst_probe u_dphst_probe (.clk(clk), .pin(pin), .p_lo(p_lo));
   // =======================
   // stand-ins and monitors
   always begin
      @(negedge clk);
      if (req === 1'h1) begin
         repeat (2 + ($random(seed) & 7)) @(negedge clk);
         {cap_we, cap_a, cap_d} = {we, addr, wdata};
         done = 1'h1;
         done_t = u_dphst_probe.cyc;
         @(negedge clk) done = 1'h0;
         @(negedge clk);
      end
   end
   // step drops then raises background; resume only drops it
   always begin
      @(negedge clk);
      k = {ebr, go, step};
      if (k == 3'b001) begin
         steps++;
         repeat (8) @(negedge clk);
         bg = 1'h0;
      end
      if (k != 3'b000) begin
         repeat (12) @(negedge clk);
         bg = k != 3'b010;
         bg_t = u_dphst_probe.cyc;
      end
   end
   always @(posedge clk) begin
      if (oe === 1'h1 && o === 1'h0) low_n <= low_n + 1;
      if (oe === 1'h1 && !oe_q) ack_t <= u_dphst_probe.cyc;
      if (oe !== 1'h1 && oe_q) begin
         pulses <= pulses + 1;
         last_low <= low_n;
         low_n <= 0;
      end
      oe_q <= oe === 1'h1;
   end
   always @(posedge clk) if (u_dphst_probe.cyc == 40000) begin
      failures++;
      end_sim();
   end
   // =======================
   // tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_ack(input logic exp);
      for (int i = 0; i < 500 && pulses == p0; i++) @(negedge clk);
      chk("ack", pulses != p0, exp);
      if (exp) begin
         chk("ack_low", last_low, 16);
         chk("ack_gap", ack_t >= u_dphst_probe.fall_t + 47, 1'h1);
         chk("ack_cause", ack_t > done_t && ack_t > bg_t, 1'h1);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      p0 = pulses;
      u_dphst_probe.byte_out(op);
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // =======================
   // sequence
   initial begin
      repeat (8) @(negedge clk);
      rstn = 1'h1;
      repeat (6) @(negedge clk);
      chk("hs_rst", hs, 1'h0);
      cmd(OP_ACK_EN);
      wait_ack(1'h1);
      chk("hs_on", hs, 1'h1);
      for (int i = 0; i < 6; i++) begin
         {a, d} = $random(seed);
         if (i == 0) a = 16'hffff;
         rdata = 16'($random(seed));
         if (i[0]) begin
            cmd(OP_READ);
            u_dphst_probe.word_out(a);
            wait_ack(1'h1);
            u_dphst_probe.read_in(v);
            chk("rdata", v, rdata);
         end else begin
            cmd(OP_WRITE);
            u_dphst_probe.word_out(a);
            u_dphst_probe.word_out(d);
            wait_ack(1'h1);
            chk("wdata", cap_d, d);
         end
         chk("addr", {cap_we, cap_a}, {!i[0], a});
      end
      cmd(OP_HALT_TO_DEBUG_INSTRUCTION);
      wait_ack(1'h1);
      cmd(OP_STEP);
      wait_ack(1'h1);
      chk("steps", steps, 1);
      cmd(OP_GO_UNTIL);
      repeat (100) @(negedge clk);
      bg = 1'h1;
      bg_t = u_dphst_probe.cyc;
      wait_ack(1'h1);
      cmd(OP_GO);
      wait_ack(1'h1);
      cmd(OP_HALT_TO_DEBUG_INSTRUCTION);
      wait_ack(1'h1);
      cmd(OP_GO_UNTIL);
      repeat (60) @(negedge clk);
      u_dphst_probe.sync_req();
      for (int i = 0; i < 400 && pulses == p0; i++) @(negedge clk);
      chk("sync_low", last_low, 128);
      chk("sync_dly", (ack_t - u_dphst_probe.rel_t) inside {[18:23]}, 1'h1);
      p0 = pulses;
      bg = 1'h1;
      wait_ack(1'h0);
      cmd(OP_ACK_DIS);
      repeat (100) @(negedge clk);
      chk("hs_off", hs, 1'h0);
      cmd(OP_WRITE);
      u_dphst_probe.word_out(a);
      u_dphst_probe.word_out(d);
      wait_ack(1'h0);
      for (int i = 0; i < 3; i++) u_dphst_probe.bit_out(1'h0);
      repeat (600) @(negedge clk);
      cmd(OP_ACK_EN);
      wait_ack(1'h1);
      cmd(OP_RUN_WITH_TAGS_CMD);
      repeat (40) @(negedge clk);
      chk("tagging", tagm, 1'h1);
      for (int i = 0; i < 12; i++) begin
         r = (i < 8) ? i[2:0] : 3'($random(seed));
         u_dphst_probe.p_lo = r[2];
         tlo = !r[1];
         lse = r[0];
         repeat (6) @(negedge clk);
         ebc = 1'h0;
         repeat (8) @(negedge clk);
         ebc = 1'h1;
         chk("tags", {thi, tlo_q}, {r[2], r[1] & r[0]});
      end
      u_dphst_probe.p_lo = 1'h0;
      repeat (60) @(negedge clk);
      chk("no_ack", pulses, p0);
      bg = 1'h1;
      repeat (5) @(negedge clk);
      chk("tag_end", tagm, 1'h0);
      end_sim();
   end
endmodule
